//--- logic/uart_interrupt_logic.sv
`timescale 1ns/1ps
module uart_interrupt_logic (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic overrun_event,
    input wire logic parity_event,
    input wire logic framing_event,
    input wire logic break_event,
    input wire logic rx_char_ready_flag,
    input wire logic rx_trigger_reached,
    input wire logic rx_timeout,
    input wire logic fifo_has_error,
    input wire logic tx_holding_empty,
    input wire logic tx_fifo_empty,
    input wire logic carrier_change_event,
    input wire logic ring_trailing_event,
    input wire logic set_ready_change_event,
    input wire logic clear_send_change_event,
    input wire logic rx_count_event,
    input wire logic tx_count_event,
    output logic port_one_request,
    output logic port_two_request
);
    import uart_irq_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [3:0] interrupt_enable_reg;
    logic [4:0] modem_control_reg;
    logic fifo_mode_enable;
    logic [1:0] general_control_reg;
    logic [1:0] general_status_reg;
    logic irq_routing_reg;
    logic overrun_flag;
    logic parity_error_flag;
    logic framing_error_flag;
    logic break_seen_flag;
    logic [3:0] modem_flags;
    logic err_fifo_flag;
    logic irq_master_gate;
    logic loop_on;
    logic rx_data_int_enable;
    logic modem_change_int_enable;
    logic wr;
    logic rd;
    logic ls_read;
    logic ms_read;
    logic gs_write;
    logic tx_empty_flag;
    logic rx_src;
    logic request;
    irq_src_if src ();

    // bus decode and control bit taps; a write needs the low byte lane
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
    assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
    assign ls_read = rd & (wb_adr_i == OFS_LINE_STATUS);
    assign ms_read = rd & (wb_adr_i == OFS_MODEM_STATUS);
    assign gs_write = wr & (wb_adr_i == OFS_GEN_STATUS);
    assign irq_master_gate = modem_control_reg[MC_GATE];
    assign loop_on = modem_control_reg[MC_LOOP];
    assign rx_data_int_enable = interrupt_enable_reg[IE_RX_DATA];
    assign modem_change_int_enable = interrupt_enable_reg[IE_MODEM];

    // ack one cycle after request, dropped next cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
        end
    end

    // software written control
    always_ff @(posedge clk) begin
        if (rst) begin
            interrupt_enable_reg <= RESET_ZERO[3:0];
            modem_control_reg <= RESET_ZERO[4:0];
            fifo_mode_enable <= RESET_ZERO[0];
            general_control_reg <= RESET_ZERO[1:0];
            irq_routing_reg <= RESET_ZERO[0];
        end else if (wr) begin
            unique case (wb_adr_i)
                OFS_INT_ENABLE: interrupt_enable_reg <= wb_dat_i[3:0];
                OFS_MODEM_CONTROL: modem_control_reg <= wb_dat_i[4:0];
                OFS_FIFO_CONTROL: fifo_mode_enable <= wb_dat_i[0];
                OFS_GEN_CONTROL: general_control_reg <= wb_dat_i[1:0];
                OFS_ROUTING: irq_routing_reg <= wb_dat_i[0];
                default: ;
            endcase
        end
    end

    // line errors: event wins over read clear
    always_ff @(posedge clk) begin
        if (rst) begin
            overrun_flag <= 1'b0;
            parity_error_flag <= 1'b0;
            framing_error_flag <= 1'b0;
            break_seen_flag <= 1'b0;
        end else begin
            overrun_flag <= overrun_event | (overrun_flag & ~ls_read);
            parity_error_flag <= parity_event | (parity_error_flag & ~ls_read);
            framing_error_flag <= framing_event | (framing_error_flag & ~ls_read);
            break_seen_flag <= break_event | (break_seen_flag & ~ls_read);
        end
    end

    // error-in-fifo clears on read once fifo holds no bad data
    always_ff @(posedge clk) begin
        if (rst) begin
            err_fifo_flag <= 1'b0;
        end else if (fifo_has_error & fifo_mode_enable) begin
            err_fifo_flag <= 1'b1;
        end else if (ls_read | ~fifo_mode_enable) begin
            err_fifo_flag <= 1'b0;
        end
    end

    // modem deltas, cleared by reading modem status
    always_ff @(posedge clk) begin
        if (rst) begin
            modem_flags <= RESET_ZERO[3:0];
        end else begin
            modem_flags <= {clear_send_change_event, set_ready_change_event,
                ring_trailing_event, carrier_change_event} | (modem_flags & {4{~ms_read}});
        end
    end

    // dma count flags, write one to clear, set wins
    always_ff @(posedge clk) begin
        if (rst) begin
            general_status_reg <= RESET_ZERO[1:0];
        end else begin
            general_status_reg[GS_RX_TC] <= rx_count_event
                | (general_status_reg[GS_RX_TC] & ~(gs_write & wb_dat_i[GS_RX_TC]));
            general_status_reg[GS_TX_TC] <= tx_count_event
                | (general_status_reg[GS_TX_TC] & ~(gs_write & wb_dat_i[GS_TX_TC]));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // source selection
    assign tx_empty_flag = fifo_mode_enable ? tx_fifo_empty : tx_holding_empty;
    assign rx_src = fifo_mode_enable ? rx_trigger_reached : rx_char_ready_flag;
    assign src.line = interrupt_enable_reg[IE_LINE] & (overrun_flag | parity_error_flag
        | framing_error_flag | break_seen_flag);
    assign src.rx_data = rx_data_int_enable & rx_src;
    assign src.timeout = rx_data_int_enable & fifo_mode_enable & rx_timeout;
    assign src.tx_empty = interrupt_enable_reg[IE_TX_EMPTY] & tx_empty_flag;
    assign src.modem = modem_change_int_enable & (|modem_flags);

    // priority encoder over the enabled sources
    irq_priority u_prio (
        .src(src.encoder),
        .fifo_mode_enable(fifo_mode_enable)
    );

    // combined level request, gated by master gate and loopback
    assign request = (src.pending
        | (general_control_reg[GC_RX_TC_EN] & general_status_reg[GS_RX_TC])
        | (general_control_reg[GC_TX_TC_EN] & general_status_reg[GS_TX_TC]))
        & irq_master_gate & ~loop_on;

    // registered outputs, routed to one controller input
    always_ff @(posedge clk) begin
        if (rst) begin
            port_one_request <= 1'b0;
            port_two_request <= 1'b0;
        end else begin
            port_one_request <= request & ~irq_routing_reg;
            port_two_request <= request & irq_routing_reg;
        end
    end

    // read data; flags readable regardless of gate
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_dat_o <= RESET_ZERO;
        end else if (rd) begin
            wb_dat_o <= RESET_ZERO;
            unique case (wb_adr_i)
                OFS_INT_ENABLE: wb_dat_o[3:0] <= interrupt_enable_reg;
                OFS_INT_IDENT: wb_dat_o[3:0] <= {src.ident, ~src.pending};
                OFS_LINE_STATUS: wb_dat_o[7:0] <= {err_fifo_flag, 1'b0, tx_empty_flag,
                    break_seen_flag, framing_error_flag, parity_error_flag, overrun_flag,
                    rx_char_ready_flag};
                OFS_MODEM_STATUS: wb_dat_o[3:0] <= modem_flags;
                OFS_MODEM_CONTROL: wb_dat_o[4:0] <= modem_control_reg;
                OFS_FIFO_CONTROL: wb_dat_o[0] <= fifo_mode_enable;
                OFS_GEN_CONTROL: wb_dat_o[1:0] <= general_control_reg;
                OFS_GEN_STATUS: wb_dat_o[1:0] <= general_status_reg;
                OFS_ROUTING: wb_dat_o[0] <= irq_routing_reg;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    // request gating, codes and clears
    property p_gate;
        @(posedge clk) disable iff (rst) !irq_master_gate
            |=> !(port_one_request | port_two_request);
    endproperty
    a_gate: assert property (p_gate) else $error("request while gate low");
    property p_loop;
        @(posedge clk) disable iff (rst) loop_on |=> !(port_one_request | port_two_request);
    endproperty
    a_loop: assert property (p_loop) else $error("request in loopback");
    property p_line_first;
        @(posedge clk) disable iff (rst) src.line |-> src.ident == 3'h3;
    endproperty
    a_line_first: assert property (p_line_first) else $error("line not first");
    property p_nonfifo_top;
        @(posedge clk) disable iff (rst) !fifo_mode_enable |-> !src.ident[2];
    endproperty
    a_nonfifo_top: assert property (p_nonfifo_top) else $error("top bit set");
    property p_unused;
        @(posedge clk) disable iff (rst) src.ident != 3'h4 && src.ident != 3'h5
            && src.ident != 3'h7;
    endproperty
    a_unused: assert property (p_unused) else $error("unused code");
    property p_route;
        @(posedge clk) disable iff (rst) !(port_one_request && port_two_request);
    endproperty
    a_route: assert property (p_route) else $error("both requests");
    property p_clear;
        @(posedge clk) disable iff (rst) ls_read && !overrun_event |=> !overrun_flag;
    endproperty
    a_clear: assert property (p_clear) else $error("overrun not cleared");
    property p_level;
        @(posedge clk) disable iff (rst) src.pending && irq_master_gate && !loop_on
            |=> port_one_request | port_two_request;
    endproperty
    a_level: assert property (p_level) else $error("request missing");
    property p_tc;
        @(posedge clk) disable iff (rst) rx_count_event |=> general_status_reg[GS_RX_TC];
    endproperty
    a_tc: assert property (p_tc) else $error("count flag lost");
    property p_tc_tx;
        @(posedge clk) disable iff (rst) tx_count_event |=> general_status_reg[GS_TX_TC];
    endproperty
    a_tc_tx: assert property (p_tc_tx) else $error("tx count flag lost");

    // identification order below the line source
    property p_rx_second;
        @(posedge clk) disable iff (rst) !src.line && src.rx_data |-> src.ident == ID_RX_DATA;
    endproperty
    a_rx_second: assert property (p_rx_second) else $error("data not second");
    property p_timeout_code;
        @(posedge clk) disable iff (rst) rx_timeout && rx_data_int_enable && fifo_mode_enable
            && !src.line && !src.rx_data |-> src.ident == ID_TIMEOUT;
    endproperty
    a_timeout_code: assert property (p_timeout_code) else $error("timeout code wrong");
    property p_tx_third;
        @(posedge clk) disable iff (rst) src.tx_empty && !src.line
            && !src.rx_data && !src.timeout |-> src.ident == ID_TX_EMPTY;
    endproperty
    a_tx_third: assert property (p_tx_third) else $error("tx empty not third");
    property p_idle_code;
        @(posedge clk) disable iff (rst) !src.pending |-> src.ident == ID_MODEM;
    endproperty
    a_idle_code: assert property (p_idle_code) else $error("idle code wrong");

    // status flags: set by their events, kept until read; error in fifo stays out of the line source
    property p_break;
        @(posedge clk) disable iff (rst) break_event |=> break_seen_flag;
    endproperty
    a_break: assert property (p_break) else $error("break flag lost");
    property p_ring;
        @(posedge clk) disable iff (rst) ring_trailing_event |=> modem_flags[1];
    endproperty
    a_ring: assert property (p_ring) else $error("ring flag lost");
    property p_flag_held;
        @(posedge clk) disable iff (rst) overrun_flag && !ls_read |=> overrun_flag;
    endproperty
    a_flag_held: assert property (p_flag_held) else $error("overrun flag dropped");
    property p_err_fifo;
        @(posedge clk) disable iff (rst) err_fifo_flag && !(overrun_flag || parity_error_flag
            || framing_error_flag || break_seen_flag) |-> !src.line;
    endproperty
    a_err_fifo: assert property (p_err_fifo) else $error("error in fifo raised line");

    // routing of the registered request
    property p_route_one;
        @(posedge clk) disable iff (rst) request && !irq_routing_reg |=> port_one_request;
    endproperty
    a_route_one: assert property (p_route_one) else $error("request not on port one");
    property p_route_two;
        @(posedge clk) disable iff (rst) request && irq_routing_reg |=> port_two_request;
    endproperty
    a_route_two: assert property (p_route_two) else $error("request not on port two");

    // scenarios worth seeing in a run
    c_req: cover property (@(posedge clk) port_one_request);
    c_req2: cover property (@(posedge clk) port_two_request);
    c_timeout: cover property (@(posedge clk) src.ident == 3'h6);
    c_line_over_rx: cover property (@(posedge clk) src.line && src.rx_data);
    c_loop_blocked: cover property (@(posedge clk) loop_on && src.pending);
endmodule : uart_interrupt_logic

//--- pkg/uart_irq_pkg.sv
package uart_irq_pkg;
    localparam logic [7:0] OFS_INT_ENABLE = 8'h00;
    localparam logic [7:0] OFS_INT_IDENT = 8'h04;
    localparam logic [7:0] OFS_LINE_STATUS = 8'h08;
    localparam logic [7:0] OFS_MODEM_STATUS = 8'h0C;
    localparam logic [7:0] OFS_MODEM_CONTROL = 8'h10;
    localparam logic [7:0] OFS_FIFO_CONTROL = 8'h14;
    localparam logic [7:0] OFS_GEN_CONTROL = 8'h18;
    localparam logic [7:0] OFS_GEN_STATUS = 8'h1C;
    localparam logic [7:0] OFS_ROUTING = 8'h20;
    // interrupt enable bits
    localparam int IE_RX_DATA = 0;
    localparam int IE_TX_EMPTY = 1;
    localparam int IE_LINE = 2;
    localparam int IE_MODEM = 3;
    // modem control bits
    localparam int MC_GATE = 3;
    localparam int MC_LOOP = 4;
    // general control / status bits
    localparam int GC_RX_TC_EN = 0;
    localparam int GC_TX_TC_EN = 1;
    localparam int GS_RX_TC = 0;
    localparam int GS_TX_TC = 1;
    // line status bits
    localparam int LS_READY = 0;
    localparam int LS_OVERRUN = 1;
    localparam int LS_PARITY = 2;
    localparam int LS_FRAMING = 3;
    localparam int LS_BREAK = 4;
    localparam int LS_TX_EMPTY = 5;
    localparam int LS_ERR_FIFO = 7;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
    typedef enum logic [2:0] {
        ID_MODEM = 3'h0,
        ID_TX_EMPTY = 3'h1,
        ID_RX_DATA = 3'h2,
        ID_LINE = 3'h3,
        ID_TIMEOUT = 3'h6
    } ident_t;
    localparam logic NO_PENDING = 1'b1;
endpackage : uart_irq_pkg

//--- pkg/irq_src_if.sv
`timescale 1ns/1ps
// pending sources between the top and the priority encoder
interface irq_src_if;
    logic line;
    logic rx_data;
    logic timeout;
    logic tx_empty;
    logic modem;
    logic [2:0] ident;
    logic pending;
    modport producer (output line, rx_data, timeout, tx_empty, modem, input ident, pending);
    modport encoder (input line, rx_data, timeout, tx_empty, modem, output ident, pending);
endinterface : irq_src_if

//--- logic/irq_priority.sv
`timescale 1ns/1ps
// priority encoder of the enabled pending sources
module irq_priority (
    irq_src_if.encoder src,
    input wire logic fifo_mode_enable
);
    import uart_irq_pkg::*;
    logic [2:0] code;
    // highest pending source wins
    always_comb begin
        code = ID_MODEM;
        if (src.line) begin
            code = ID_LINE;
        end else if (src.rx_data) begin
            code = ID_RX_DATA;
        end else if (src.timeout) begin
            code = ID_TIMEOUT;
        end else if (src.tx_empty) begin
            code = ID_TX_EMPTY;
        end
    end
    // top bit masked outside FIFO mode
    assign src.ident = {code[2] & fifo_mode_enable, code[1:0]};
    assign src.pending = src.line | src.rx_data | src.timeout | src.tx_empty | src.modem;
endmodule : irq_priority

//--- bench/irq_controller_model.sv
`timescale 1ns/1ps
// system interrupt controller stand-in: samples both port request inputs
module irq_controller_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_one,
    input wire logic req_two,
    output logic [1:0] level
);
    // level-sensitive request inputs, sampled every clock
    always_ff @(posedge clk) begin
        if (rst) begin
            level <= 2'h0;
        end else begin
            level <= {req_two, req_one};
        end
    end
endmodule : irq_controller_model

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
    import uart_irq_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    // line errors [3:0], modem deltas [7:4], dma counts [9:8]
    logic [9:0] ev = 10'h000;
    logic ready = 1'b0, trig = 1'b0, tmo = 1'b0, ferr = 1'b0, thold = 1'b0, tfifo = 1'b0;
    logic one, two;
    logic [1:0] lvl;
    int miscompares = 0, n_tests = 0, cycles = 0;

    uart_interrupt_logic u_uart_interrupt_logic (
        .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .overrun_event(ev[0]), .parity_event(ev[1]), .framing_event(ev[2]),
        .break_event(ev[3]), .rx_char_ready_flag(ready), .rx_trigger_reached(trig),
        .rx_timeout(tmo), .fifo_has_error(ferr), .tx_holding_empty(thold),
        .tx_fifo_empty(tfifo), .carrier_change_event(ev[4]), .ring_trailing_event(ev[5]),
        .set_ready_change_event(ev[6]), .clear_send_change_event(ev[7]),
        .rx_count_event(ev[8]), .tx_count_event(ev[9]),
        .port_one_request(one), .port_two_request(two)
    );
    irq_controller_model u_irq_controller_model (
        .clk(clk), .rst(rst), .req_one(one), .req_two(two), .level(lvl)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // clock, and a ceiling of 20000 cycles, well above the few hundred cycles the tests need
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // classic single wishbone cycle; read data taken at the ack edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= v;
        do @(posedge clk); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e,
                          input logic [31:0] m);
        bus(1'b0, a, 32'h0);
        chk(n, e, rdat & m);
    endtask : rd_chk

    task automatic id(input logic [31:0] e);
        repeat (2) @(posedge clk);
        rd_chk("ident", OFS_INT_IDENT, e, 32'hF);
    endtask : id

    task automatic rq(input logic [1:0] e);
        repeat (4) @(posedge clk);
        chk("request", {30'h0, e}, {30'h0, lvl});
    endtask : rq

    task automatic pulse(input int b);
        @(posedge clk);
        ev[b] <= 1'b1;
        @(posedge clk);
        ev <= 10'h000;
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        id(32'h1);
        rq(2'h0);
        rd_chk("unmapped", 8'h30, 32'h0, 32'hFFFFFFFF);
        bus(1'b1, OFS_ROUTING, 32'h0);
        sel <= 4'h0;
        bus(1'b1, OFS_ROUTING, 32'h1);
        sel <= 4'hF;
        rd_chk("masked write", OFS_ROUTING, 32'h0, 32'h1);
        bus(1'b1, OFS_INT_ENABLE, 32'hF);
        bus(1'b1, OFS_MODEM_CONTROL, 32'h1 << MC_GATE);
        thold <= 1'b1;
        id(32'h2);
        rq(2'h1);
        rd_chk("tx empty flag", OFS_LINE_STATUS, 32'h20, 32'h20);
        for (int i = 0; i < 4; i++) begin
            pulse(i);
            id(32'h6);
            rd_chk("line flags", OFS_LINE_STATUS, 32'h2 << i, 32'h1E);
            id(32'h2);
        end
        ready <= 1'b1;
        id(32'h4);
        bus(1'b1, OFS_MODEM_CONTROL, 32'h0);
        rq(2'h0);
        rd_chk("ready flag", OFS_LINE_STATUS, 32'h21, 32'h21);
        bus(1'b1, OFS_MODEM_CONTROL, 32'h18);
        rq(2'h0);
        bus(1'b1, OFS_MODEM_CONTROL, 32'h8);
        rq(2'h1);
        ready <= 1'b0;
        bus(1'b1, OFS_FIFO_CONTROL, 32'h1);
        id(32'h1);
        tfifo <= 1'b1;
        id(32'h2);
        tmo <= 1'b1;
        id(32'hC);
        bus(1'b1, OFS_INT_ENABLE, 32'hE);
        id(32'h2);
        bus(1'b1, OFS_INT_ENABLE, 32'hF);
        tmo <= 1'b0;
        trig <= 1'b1;
        id(32'h4);
        rd_chk("no trigger flag", OFS_LINE_STATUS, 32'h0, 32'h1);
        trig <= 1'b0;
        tmo <= 1'b1;
        bus(1'b1, OFS_FIFO_CONTROL, 32'h0);
        id(32'h2);
        tmo <= 1'b0;
        thold <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            pulse(4 + i);
            id(32'h0);
            rd_chk("modem flags", OFS_MODEM_STATUS, 32'h1 << i, 32'hF);
            id(32'h1);
        end
        bus(1'b1, OFS_INT_ENABLE, 32'h0);
        bus(1'b1, OFS_GEN_CONTROL, 32'h3);
        for (int i = 0; i < 2; i++) begin
            pulse(8 + i);
            rq(2'h1);
            rd_chk("count flags", OFS_GEN_STATUS, 32'h1 << i, 32'h3);
            bus(1'b1, OFS_GEN_STATUS, 32'h1 << i);
            rq(2'h0);
        end
        bus(1'b1, OFS_GEN_CONTROL, 32'h1);
        pulse(9);
        rq(2'h0);
        rd_chk("count flag", OFS_GEN_STATUS, 32'h2, 32'h3);
        bus(1'b1, OFS_GEN_STATUS, 32'h2);
        bus(1'b1, OFS_INT_ENABLE, 32'h4);
        bus(1'b1, OFS_FIFO_CONTROL, 32'h1);
        ferr <= 1'b1;
        rq(2'h0);
        rd_chk("error in fifo", OFS_LINE_STATUS, 32'h80, 32'h80);
        ferr <= 1'b0;
        bus(1'b0, OFS_LINE_STATUS, 32'h0);
        rd_chk("error in fifo cleared", OFS_LINE_STATUS, 32'h0, 32'h80);
        bus(1'b1, OFS_FIFO_CONTROL, 32'h0);
        bus(1'b1, OFS_ROUTING, 32'h1);
        bus(1'b1, OFS_INT_ENABLE, 32'h2);
        thold <= 1'b1;
        rq(2'h2);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rq(2'h0);
        id(32'h1);
        rd_chk("routing after reset", OFS_ROUTING, 32'h0, 32'h1);
        finish_test();
    end
endmodule : tb
